// [core/pwd_supervisor.sv]
/*
 Watchdog, on-key front end, interrupt pin and first stage of
 the on/off controller, with an APB register slave.
 Assumes pins are asynchronous to pclk; fuses are static.
*/
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "pwd_params.svh"
module pwd_supervisor import pwd_pkg::*; #(
  parameter int TICK_CYC  = `PWD_CLK_HZ * `PWD_TICK_S,
  parameter int SEQDN_CYC = `PWD_CLK_HZ / 1000 * `PWD_SEQDN_MS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        main_battery_uv,
  input  wire logic        main_battery_ov,
  input  wire logic        slow_osc_ok,
  input  wire logic        bias_ready,
  input  wire logic        onkey_input,
  input  wire logic        second_enable_input,
  input  wire logic        adapter_ok_input,
  input  wire logic        reset_io_i,
  input  wire logic        sudden_loss_event,
  input  wire logic        rtc_alarm_a,
  input  wire logic        rtc_alarm_b,
  input  wire logic        sequencer_aux_on,
  input  wire logic        wdog_enable_fuse,
  input  wire logic [1:0]  onkey_mode_fuse,
  input  wire logic        onkey_polarity_fuse,
  output logic             reset_io_o,
  output logic             reset_io_oe,
  output logic             irq_out_n_o,
  output logic             irq_out_n_oe,
  output logic             sequencer_main_en,
  output logic             sequencer_aux_en,
  output logic             global_shutdown,
  output logic             immediate_shutdown
);

  pwd_pins_s  pin_raw, meta_q, pin_q, prev_q;
  pwd_state_e state_q, state_d;
  logic [7:0] ctrl_q, wake_q, sts_q, msk_q, evt;
  logic [7:0] wd_cnt_q, wd_lim;
  logic [1:0] fuse_cnt_q;
  logic [31:0] tick_cnt_q, seq_cnt_q;
  logic [31:0] rd_d, prdata_q;
  logic       tick, wd_exp, wr, rd_ok, imm, wake_any, wake_pend_q;
  logic       onk_act, onk_prev_q, onk_evt, wd_record_q, rst_drv_q;
  logic       wr_clr, auto_clr, rd_set, imm_q, irq_q;

  // Seconds that each period code stands for
  function automatic logic [7:0] per_secs(input logic [1:0] f);
    unique case (f)
      2'b00: per_secs = `PWD_PER0_S;
      2'b01: per_secs = `PWD_PER1_S;
      2'b10: per_secs = `PWD_PER2_S;
      2'b11: per_secs = `PWD_PER3_S;
    endcase
  endfunction

  // Address match for every mapped word
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `PWD_A_CTRL) || (a == `PWD_A_WAKE) ||
             (a == `PWD_A_ISTS) || (a == `PWD_A_IMSK) ||
             (a == `PWD_A_STAT);
  endfunction

  assign pin_raw = '{main_battery_uv, main_battery_ov, slow_osc_ok,
                     bias_ready, onkey_input, second_enable_input,
                     adapter_ok_input, reset_io_i, sudden_loss_event,
                     rtc_alarm_a, rtc_alarm_b, sequencer_aux_on,
                     wdog_enable_fuse};

  // Two-flop synchroniser; meta_q feeds nothing else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      pin_q  <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_raw;
      pin_q  <= meta_q;
      prev_q <= pin_q;
    end
  end

  // APB handshake: zero wait states, read data latched at setup
  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite && mapped(paddr);
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata  = prdata_q;
  assign wr_clr  = wr && paddr == `PWD_A_CTRL &&
                   pwdata[`PWD_F_CLR] == `PWD_CLR_PAT;

  always_comb begin
    rd_d = '0;
    unique case (paddr)
      `PWD_A_CTRL: rd_d[5:0] = ctrl_q[5:0];  // Clear field reads 0
      `PWD_A_WAKE: rd_d[3:0] = wake_q[3:0];
      `PWD_A_ISTS: rd_d[7:0] = sts_q;
      `PWD_A_IMSK: rd_d[7:0] = msk_q;
      `PWD_A_STAT: rd_d[19:0] = {wd_record_q, state_q, wd_cnt_q, 8'h00};
      default:     rd_d = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= rd_d;
    end
  end

  // Immediate shutdown causes, staged by controller state
  always_comb begin
    imm = pin_q.bat_uv || pin_q.bat_ov;
    if (!pin_q.osc_ok && state_q != ST_NOPWR) imm = 1'b1;
    if (!pin_q.bias_ok && (state_q == ST_READY || state_q == ST_ON ||
        state_q == ST_SEQDN)) imm = 1'b1;
  end

  // Fuse load delay: synchroniser must settle before sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_cnt_q <= 2'h0;
    end else if (imm) begin
      fuse_cnt_q <= 2'h0;
    end else if (fuse_cnt_q != `PWD_FUSE_WAIT) begin
      fuse_cnt_q <= fuse_cnt_q + 2'h1;
    end
  end

  // Control and wake-enable registers; cleared by any immediate shutdown cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PWD_CTRL_RST;
      wake_q <= 8'h00;
      msk_q  <= `PWD_MSK_RST;
    end else if (imm) begin
      ctrl_q <= `PWD_CTRL_RST;
      wake_q <= 8'h00;
      msk_q  <= `PWD_MSK_RST;
    end else begin
      if (fuse_cnt_q == `PWD_FUSE_WAIT - 2'h1)
        ctrl_q[`PWD_B_WDEN] <= pin_q.wd_fuse;
      if (wr && paddr == `PWD_A_CTRL) ctrl_q <= {2'b00, pwdata[5:0]};
      if (wr && paddr == `PWD_A_WAKE) wake_q <= {4'h0, pwdata[3:0]};
      if (wr && paddr == `PWD_A_IMSK) msk_q <= pwdata[7:0];
    end
  end

  // One-second timebase from pclk, held while disabled
  assign tick = tick_cnt_q == TICK_CYC - 1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (!ctrl_q[`PWD_B_WDEN] || tick || wr_clr) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  assign wd_lim   = per_secs(ctrl_q[`PWD_F_PER]);
  assign wd_exp   = ctrl_q[`PWD_B_WDEN] && wd_cnt_q == wd_lim &&
                    state_q == ST_ON;
  assign auto_clr = ctrl_q[`PWD_B_AUTO] && !pin_q.aux_on;

  // Watchdog seconds counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_q <= 8'h00;
    end else if (imm || wd_exp) begin
      wd_cnt_q <= 8'h00;
    end else if (wr_clr) begin
      wd_cnt_q <= 8'h00;
    end else if (auto_clr) begin
      wd_cnt_q <= 8'h00;
    end else if (ctrl_q[`PWD_B_WDEN] && tick && wd_cnt_q != wd_lim) begin
      wd_cnt_q <= wd_cnt_q + 8'h01;
    end
  end

  assign onk_act = pin_q.onkey ^ onkey_polarity_fuse;
  // Push-button takes edges, other modes take the level
  assign onk_evt = (onkey_mode_fuse == 2'b00) ? (onk_act && !onk_prev_q)
                                             : onk_act;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      onk_prev_q <= 1'b0;
    end else begin
      onk_prev_q <= onk_act;
    end
  end

  // Event sources: watchdog expiry, falling edge of the reset pin, rising edges of the active on-key, second enable, adapter, sudden loss and both alarms
  assign evt = {pin_q.alarm_b & ~prev_q.alarm_b,
                pin_q.alarm_a & ~prev_q.alarm_a,
                pin_q.sloss & ~prev_q.sloss,
                ~pin_q.rst_pin & prev_q.rst_pin & ~rst_drv_q,  // Own pull is no event
                pin_q.adapter & ~prev_q.adapter,
                pin_q.en2 & ~prev_q.en2,
                onk_act & ~onk_prev_q,
                wd_exp};

  // Maskable wakes gated by their enables
  assign wake_any = (pin_q.adapter && wake_q[0]) ||
                    (evt[6] && wake_q[1]) || (evt[7] && wake_q[2]) ||
                    (onk_evt && wake_q[3]) ||
                    evt[5] || evt[2] || evt[4];  // Adapter only via gated level

  // Sticky status, set wins over write-one-clear
  assign rd_set = wr && paddr == `PWD_A_ISTS;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= 8'h00;
    end else if (imm) begin
      sts_q <= 8'h00;
    end else begin
      sts_q <= (sts_q & ~(rd_set ? pwdata[7:0] : 8'h00)) | evt;
    end
  end

  // Open-drain interrupt, pulled low while pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(sts_q & ~msk_q);
    end
  end

  // Expiry recorded; survives shutdowns until presetn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_record_q <= 1'b0;
    end else if (wd_exp) begin
      wd_record_q <= 1'b1;
    end
  end

  // Controller states
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_NOPWR:   if (pin_q.osc_ok && !pin_q.bat_uv && !pin_q.bat_ov)
                    state_d = ST_STANDBY;
      ST_STANDBY: if (pin_q.bias_ok) state_d = ST_READY;
      ST_READY:   if (wake_pend_q) state_d = ST_ON;
      ST_ON:      if (wd_exp) state_d = ST_SEQDN;
      ST_SEQDN:   if (seq_cnt_q == SEQDN_CYC - 1) state_d = ST_STANDBY;
      default:    state_d = ST_NOPWR;
    endcase
    if (imm) state_d = ST_NOPWR;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_NOPWR;
    end else begin
      state_q <= state_d;
    end
  end

  // Sequenced shutdown length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_cnt_q <= 32'h0000_0000;
    end else if (state_q != ST_SEQDN) begin
      seq_cnt_q <= 32'h0000_0000;
    end else begin
      seq_cnt_q <= seq_cnt_q + 32'h0000_0001;
    end
  end

  // Wake latch; consumed on power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pend_q <= 1'b0;
    end else if (imm || state_q == ST_ON) begin
      wake_pend_q <= 1'b0;
    end else if (state_q == ST_SEQDN && state_d == ST_STANDBY) begin
      wake_pend_q <= ctrl_q[`PWD_B_WKWD];
    end else if (wake_any) begin
      wake_pend_q <= 1'b1;
    end
  end

  // Reset pin driver registered off the next state, shutdown flag off imm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_drv_q <= 1'b1;
      imm_q     <= 1'b0;
    end else begin
      // Reset pin held low outside on state
      rst_drv_q <= state_d != ST_ON;
      imm_q     <= imm;
    end
  end

  assign reset_io_o         = 1'b0;
  assign reset_io_oe        = rst_drv_q;
  assign irq_out_n_o        = 1'b0;
  assign irq_out_n_oe       = irq_q;
  assign sequencer_main_en  = state_q == ST_ON;
  assign sequencer_aux_en   = state_q == ST_ON;
  assign global_shutdown    = state_q == ST_SEQDN;
  assign immediate_shutdown = imm_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_expire;
    state_q == ST_ON ##0 wd_exp;
  endsequence
  sequence s_down;
    state_q == ST_SEQDN [*2];
  endsequence

  bat_fault_a: assert property ((pin_q.bat_uv || pin_q.bat_ov) |=>
    state_q == ST_NOPWR && ctrl_q == `PWD_CTRL_RST)
    else $error("battery fault did not shut down");
  osc_loss_a: assert property ((!pin_q.osc_ok && state_q != ST_NOPWR) |=>
    state_q == ST_NOPWR) else $error("oscillator loss ignored");
  bias_loss_a: assert property ((!pin_q.bias_ok && state_q == ST_ON) |=>
    state_q == ST_NOPWR && immediate_shutdown)
    else $error("bias loss ignored");
  fuse_load_a: assert property ((fuse_cnt_q == 2'h2 && !imm && !wr) |=>
    ctrl_q[0] == $past(pin_q.wd_fuse)) else $error("fuse not loaded");
  wd_hold_a: assert property ((!ctrl_q[0] && !imm && !wr_clr && !auto_clr)
    |=> $stable(wd_cnt_q)) else $error("counter moved while off");
  wd_clear_a: assert property (wr_clr |=> wd_cnt_q == 8'h00)
    else $error("clear pattern ignored");
  wd_keep_a: assert property ((wr && !wr_clr && !tick && !imm && !wd_exp
    && !auto_clr) |=> $stable(wd_cnt_q)) else $error("bad clear acted");
  wd_fire_a: assert property (s_expire |=> global_shutdown && reset_io_oe
    && sts_q[0] && wd_record_q) else $error("expiry not acted on");
  auto_clr_a: assert property (auto_clr && !wr_clr |=> wd_cnt_q == 8'h00)
    else $error("auto clear failed");
  irq_pin_a: assert property ((|(sts_q & ~msk_q)) |=> irq_out_n_oe)
    else $error("interrupt pin not pulled");
  onkey_wake_a: assert property ((onk_evt && !wake_q[3] && !imm &&
    !wake_pend_q && wake_any == 1'b0) |=> !wake_pend_q)
    else $error("masked on-key woke");
  evt_sts_a: assert property ((evt[1] && !imm) |=> sts_q[1])
    else $error("event not recorded");
  standby_a: assert property ((state_q == ST_NOPWR && !imm &&
    pin_q.osc_ok) |=> state_q == ST_STANDBY) else $error("no standby");
  seq_end_a: assert property ((s_down ##0 state_d == ST_STANDBY && !imm)
    |=> wake_pend_q == $past(ctrl_q[2])) else $error("wake choice wrong");

endmodule // pwd_supervisor

// [core/pwd_params.svh]
/*
 Constants of the supervisor: register map, field positions,
 reset values and timing. Assumes a 25 MHz pclk.
*/
`ifndef PWD_PARAMS_SVH
`define PWD_PARAMS_SVH
`define PWD_A_CTRL     8'h00
`define PWD_A_WAKE     8'h04
`define PWD_A_ISTS     8'h08
`define PWD_A_IMSK     8'h0C
`define PWD_A_STAT     8'h10
`define PWD_B_WDEN     0
`define PWD_B_AUTO     1
`define PWD_B_WKWD     2
`define PWD_F_PER      5:4
`define PWD_F_CLR      7:6
`define PWD_CLR_PAT    2'b01
`define PWD_CTRL_RST   8'h00
`define PWD_MSK_RST    8'hFF
`define PWD_PER0_S     8'h02
`define PWD_PER1_S     8'h10
`define PWD_PER2_S     8'h40
`define PWD_PER3_S     8'h80
`define PWD_CLK_HZ     25000000
`define PWD_TICK_S     1
`define PWD_SEQDN_MS   10
`define PWD_FUSE_WAIT  2'h3
`endif

// [core/pwd_pkg.sv]
/*
 Types of the supervisor: controller states and pin bundle.
 Assumes nothing beyond the params header.
*/
package pwd_pkg;
  typedef enum logic [2:0] {
    ST_NOPWR, ST_STANDBY, ST_READY, ST_ON, ST_SEQDN
  } pwd_state_e;
  // Asynchronous inputs, synchronised as one bundle
  typedef struct packed {
    logic bat_uv;
    logic bat_ov;
    logic osc_ok;
    logic bias_ok;
    logic onkey;
    logic en2;
    logic adapter;
    logic rst_pin;
    logic sloss;
    logic alarm_a;
    logic alarm_b;
    logic aux_on;
    logic wd_fuse;
  } pwd_pins_s;
endpackage

// [verification/pwd_host_model.sv]
/*
 Host side of the supervisor pins: pull-ups on the reset and
 interrupt wires, and a reset button that can pull the reset wire.
 Assumes the design drives both pins open-drain through its enables.
*/
`timescale 1ns/1ps
module pwd_host_model (
  input  wire logic reset_oe,
  input  wire logic irq_oe,
  input  wire logic button,
  output logic      reset_wire,
  output logic      irq_wire
);
  // Wired-and: low while any party pulls, else the pull-up wins
  assign reset_wire = !(reset_oe || button);
  assign irq_wire   = !irq_oe;
endmodule // pwd_host_model

// [verification/pwd_supervisor_bench.sv]
/*
 Self-checking bench of the supervisor: APB tasks and directed tests.
 Assumes zero wait APB and the shortened tick and shutdown counts.
*/
`timescale 1ns/1ps
`include "pwd_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module pwd_supervisor_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic        pready, pslverr, err, uv = 0, ov = 0, osc = 0, bias = 0;
  logic        adapter = 0, aux_on = 1, button = 0, seen;
  logic [7:0]  cnt;
  logic [4:0]  ev = 5'h00;
  logic        rst_wire, irq_wire, rst_oe, irq_oe;
  int          num_errors = 0, n_tests = 0;
  int          evbit[5] = '{1, 2, 5, 6, 7};
  // 25 MHz
  always #20 pclk = ~pclk;
  pwd_supervisor #(.TICK_CYC(10), .SEQDN_CYC(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_battery_uv(uv),
    .main_battery_ov(ov), .slow_osc_ok(osc), .bias_ready(bias),
    .onkey_input(ev[0]), .second_enable_input(ev[1]),
    .adapter_ok_input(adapter), .reset_io_i(rst_wire),
    .sudden_loss_event(ev[2]), .rtc_alarm_a(ev[3]), .rtc_alarm_b(ev[4]),
    .sequencer_aux_on(aux_on), .wdog_enable_fuse(1'b1),
    .onkey_mode_fuse(2'b00), .onkey_polarity_fuse(1'b0),
    .reset_io_o(), .reset_io_oe(rst_oe), .irq_out_n_o(),
    .irq_out_n_oe(irq_oe), .sequencer_main_en(), .sequencer_aux_en(),
    .global_shutdown(), .immediate_shutdown()
  );
  pwd_host_model host (.reset_oe(rst_oe), .irq_oe(irq_oe), .button(button),
    .reset_wire(rst_wire), .irq_wire(irq_wire));
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      num_errors++;
      test_done();
    end
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Poll the controller state with a bounded number of reads
  task automatic wait_st(input logic [2:0] s);
    int i;
    i = 0;
    do begin
      xfer(`PWD_A_STAT, 0, 0);
      i++;
    end while (r[18:16] !== s && i < 200);
    `CHK(r[18:16], s)
  endtask
  task automatic wait_imm();
    int i;
    seen = 0;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (dut.immediate_shutdown === 1'b1) seen = 1;
    end
    `CHK(seen, 1'b1)
  endtask
  initial begin
    #2000000;
    num_errors++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    xfer(`PWD_A_CTRL, 0, 0);
    `CHK(r[0], 1'b1)
    // Watchdog off until powered up, else it expires on entry to on
    xfer(`PWD_A_CTRL, 1, 32'h0000_0000);
    xfer(`PWD_A_IMSK, 0, 0);
    `CHK(r[7:0], `PWD_MSK_RST)
    xfer(8'h14, 0, 0);
    `CHK(err, 1'b1)
    $display("Test reset done");
    osc <= 1;
    wait_st(3'd1);
    bias <= 1;
    wait_st(3'd2);
    // Masked adapter must not power up
    adapter <= 1;
    repeat (10) @(posedge pclk);
    xfer(`PWD_A_STAT, 0, 0);
    `CHK(r[18:16], 3'd2)
    xfer(`PWD_A_WAKE, 1, 32'h0000_0001);
    wait_st(3'd3);
    $display("Test power up done");
    xfer(`PWD_A_CTRL, 1, 32'h0000_0051);
    repeat (40) @(posedge pclk);
    xfer(`PWD_A_CTRL, 1, 32'h0000_0010);
    xfer(`PWD_A_STAT, 0, 0);
    cnt = r[15:8];
    `CHK(cnt != 8'h00, 1'b1)
    repeat (40) @(posedge pclk);
    xfer(`PWD_A_STAT, 0, 0);
    `CHK(r[15:8], cnt)
    // Same period with wake on watchdog set, so the controller rewakes after the expiry
    xfer(`PWD_A_CTRL, 1, 32'h0000_0055);
    xfer(`PWD_A_STAT, 0, 0);
    `CHK(r[15:8], 8'h00)
    repeat (12) @(posedge pclk);
    xfer(`PWD_A_CTRL, 1, 32'h0000_0095);
    xfer(`PWD_A_STAT, 0, 0);
    `CHK(r[15:8] != 8'h00, 1'b1)
    xfer(`PWD_A_IMSK, 1, 32'h0000_00FE);
    wait_st(3'd4);
    `CHK(rst_wire, 1'b0)
    xfer(`PWD_A_ISTS, 0, 0);
    `CHK(r[0], 1'b1)
    xfer(`PWD_A_STAT, 0, 0);
    `CHK(r[19], 1'b1)
    `CHK(irq_wire, 1'b0)
    wait_st(3'd3);
    xfer(`PWD_A_CTRL, 1, 32'h0000_0040);
    xfer(`PWD_A_ISTS, 1, 32'h0000_0001);
    xfer(`PWD_A_ISTS, 0, 0);
    `CHK(r[0], 1'b0)
    `CHK(irq_wire, 1'b1)
    $display("Test watchdog done");
    // Auto clear while the aux sequencer is off
    xfer(`PWD_A_CTRL, 1, 32'h0000_0043);
    aux_on <= 0;
    repeat (40) @(posedge pclk);
    xfer(`PWD_A_STAT, 0, 0);
    `CHK(r[15:8], 8'h00)
    `CHK(r[18:16], 3'd3)
    aux_on <= 1;
    xfer(`PWD_A_CTRL, 1, 32'h0000_0040);
    // Each ev pin event latches its own status bit
    for (int i = 0; i < 5; i++) begin
      ev <= 5'h01 << i;
      repeat (6) @(posedge pclk);
      ev <= 5'h00;
      repeat (6) @(posedge pclk);
      xfer(`PWD_A_ISTS, 0, 0);
      `CHK(r[evbit[i]], 1'b1)
      xfer(`PWD_A_ISTS, 1, 32'h0000_00FF);
    end
    $display("Test events done");
    uv <= 1;
    wait_imm();
    xfer(`PWD_A_STAT, 0, 0);
    `CHK(r[18:16], 3'd0)
    xfer(`PWD_A_IMSK, 0, 0);
    `CHK(r[7:0], `PWD_MSK_RST)
    uv <= 0;
    wait_st(3'd2);
    bias <= 0;
    wait_imm();
    bias <= 1;
    wait_st(3'd2);
    osc <= 0;
    wait_imm();
    wait_st(3'd0);
    $display("Test faults done");
    test_done();
  end
endmodule // pwd_supervisor_bench
